// >>> bench/cpif_monitor.sv
// cpif_monitor: timing and data checks on the bus between host and device ends
// assumes: one clock for both ends, synchronous active-high reset
`default_nettype none
module cpif_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bus wires
	input wire logic csN,
	input wire logic readNotWrite,
	input wire logic [4:0] addr,
	input wire logic [31:0] wrData,
	input wire logic [31:0] rdData,
	input wire logic ackHiN,
	input wire logic ackLoN
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// helpers
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic rdAck;
	logic woAddr;
	logic wideAddr;
	assign rdAck = !ackHiN && readNotWrite;
	assign wideAddr = addr[4:2] == 3'h4 || addr[4:3] == 2'h3;
	assign woAddr = addr[4:1] inside {4'h1, 4'h4, 4'h5, 4'h7} || addr[4:3] == 2'h3;
	// ==========================================
	// assertions
	a_ack_one_cycle: assert property (!ackHiN |=> ackHiN)
		else $error("ack held longer than one cycle");
	a_ack_after_select: assert property (!ackHiN |-> !$past(csN))
		else $error("ack without select");
	a_select_answered: assert property ($fell(csN) |-> ##[1:64] !ackHiN)
		else $error("selected cycle not acknowledged");
	a_lo_with_hi: assert property (!ackLoN |-> !ackHiN)
		else $error("low ack alone");
	a_word_upper_port: assert property (!ackHiN && !addr[4] |-> ackLoN)
		else $error("word register acked as long port");
	a_long_both_acks: assert property (!ackHiN && wideAddr |-> !ackLoN)
		else $error("long register acked as word port");
	a_word_low_zero: assert property (rdAck && !addr[4] |-> rdData[15:0] == 16'h0000)
		else $error("word read with nonzero low half");
	a_unused_all_ones: assert property (rdAck && woAddr |-> rdData[31:16] == 16'hFFFF
		&& (addr[4:3] != 2'h3 || rdData[15:0] == 16'hFFFF))
		else $error("unused or write-only read not all ones");
	a_rdata_steady: assert property ($changed(rdData) |-> rdAck)
		else $error("read data changed outside a read ack");
	c_long_read: cover property (rdAck && addr[4:3] == 2'h3);
	c_long_write: cover property (!ackLoN && !readNotWrite);
	c_response_read: cover property (rdAck && addr == 5'h00);
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: host and device ends joined by the bus interface, driven at the host request side
// assumes: second generation device, design packages compiled first
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// signals and ends
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reqValid = 1'b0;
	logic reqRead = 1'b0;
	logic [2:0] reqFc = 3'h7;
	logic [3:0] reqSpace = 4'h2;
	logic [2:0] reqCpId = 3'h1;
	logic [4:0] reqAddr = 5'h00;
	logic [31:0] reqWData = 32'h0;
	logic execBusy = 1'b0;
	logic excRaise = 1'b0;
	logic excCauseClear = 1'b0;
	logic opndReady = 1'b1;
	logic [31:0] ctxRdData = 32'h0;
	logic reqReady, rspValid, rspNoDevice, rspWide, startPulse, cancelPulse, haltPulse;
	logic excPending, opndValid;
	logic [31:0] rspData, opndData, t;
	logic [15:0] startWord;
	logic [31:0] expQ[$];
	int mismatches = 0;
	int nChecks = 0;
	int nStart = 0;
	int nHalt = 0;
	int nCancel = 0;
	int n, h;
	logic [4:0] n2[6] = '{5'h02, 5'h09, 5'h0B, 5'h0F, 5'h1D, 5'h1A};
	cpif_bus_if bus();
	cpif_host u_cpif_host (.clk, .srst, .bus(bus), .reqValid, .reqReady, .reqRead, .reqFc,
		.reqSpace, .reqCpId, .reqAddr, .reqWData, .rspValid, .rspNoDevice, .rspWide, .rspData);
	cpif_device u_cpif_device (.clk, .srst, .bus(bus), .startPulse, .startWord, .execBusy,
		.cancelPulse, .haltPulse, .excRaise, .excCauseClear, .excPending, .opndValid,
		.opndReady, .opndData, .ctxRdData, .regMaskIn(8'h5A));
	cpif_monitor u_cpif_monitor (.clk, .srst, .csN(bus.csN), .readNotWrite(bus.readNotWrite),
		.addr(bus.addr), .wrData(bus.wrData), .rdData(bus.rdData), .ackHiN(bus.ackHiN),
		.ackLoN(bus.ackLoN));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		nStart += (startPulse === 1'b1);
		nHalt += (haltPulse === 1'b1);
		nCancel += (cancelPulse === 1'b1);
		if (opndValid === 1'b1 && opndReady === 1'b1) begin
			t = expQ.pop_front();
			`CHK("opndData", t, opndData)
		end
	end
	// ==========================================
	// bus access tasks
	task automatic acc(input logic r, input logic [4:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clk);
		reqValid <= 1'b1;
		reqRead <= r;
		reqAddr <= a;
		reqWData <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		#1;
		while (rspValid !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 300) `CHK("rspValid", 1'b1, rspValid)
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		acc(1'b1, a, 32'h0);
		`CHK($sformatf("rdData %h", a), e, rspData)
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		acc(1'b0, a, d);
	endtask
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("ERROR watchdog exp done got hang");
		reportAndStop;
	end
	// ==========================================
	// tests
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		foreach (n2[i]) rd(n2[i], n2[i][4:3] == 2'h3 ? 32'hFFFFFFFF : 32'hFFFF0000);
		`CHK("rspWide", 1'b1, rspWide)
		wr(5'h00, 32'hFFFF0000);
		rd(5'h01, 32'h0);
		`CHK("rspWide", 1'b0, rspWide)
		`CHK("reqReady", 1'b0, reqReady)
		@(posedge clk) reqSpace <= 4'h3;
		rd(5'h00, 32'hFFFFFFFF);
		`CHK("rspNoDevice", 1'b1, rspNoDevice)
		`CHK("reqReady", 1'b1, reqReady)
		@(posedge clk) reqSpace <= 4'h2;
		reqCpId <= 3'h5;
		rd(5'h00, 32'hFFFFFFFF);
		`CHK("rspNoDevice", 1'b1, rspNoDevice)
		@(posedge clk) reqCpId <= 3'h1;
		$display("end map");
		wr(5'h0A, 32'h12340000);
		`CHK("nStart", 0, nStart)
		rd(5'h00, 32'h81000000);
		`CHK("nStart", 1, nStart)
		`CHK("startWord", 16'h1234, startWord)
		rd(5'h00, 32'hC0000000);
		expQ.push_back(32'hCAFE0001);
		wr(5'h10, 32'hCAFE0001);
		rd(5'h00, 32'h0);
		@(posedge clk) execBusy <= 1'b1;
		wr(5'h0A, 32'h22220000);
		rd(5'h00, 32'hC0000000);
		@(posedge clk) execBusy <= 1'b0;
		repeat (4) @(posedge clk);
		rd(5'h00, 32'h81000000);
		h = nCancel;
		wr(5'h02, 32'h00010000);
		`CHK("cancel", 1'b1, nCancel > h)
		rd(5'h00, 32'h0);
		$display("end dialog");
		@(posedge clk) excRaise <= 1'b1;
		@(posedge clk) excRaise <= 1'b0;
		rd(5'h00, 32'h1C000000);
		wr(5'h02, 32'h00020000);
		rd(5'h00, 32'h1C000000);
		`CHK("excPending", 1'b1, excPending)
		@(posedge clk) excCauseClear <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("excPending", 1'b0, excPending)
		excCauseClear <= 1'b0;
		rd(5'h00, 32'h0);
		$display("end exception");
		rd(5'h04, 32'h0);
		@(posedge clk) execBusy <= 1'b1;
		h = nHalt;
		rd(5'h04, 32'h01000000);
		`CHK("halt", 1'b1, nHalt > h)
		@(posedge clk) execBusy <= 1'b0;
		wr(5'h0A, 32'h56780000);
		rd(5'h04, 32'h18000000);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) ctxRdData <= 32'h5A5A0F00 + i;
			rd(5'h10, 32'h5A5A0F00 + i);
		end
		rd(5'h04, 32'h02000000);
		wr(5'h02, 32'h00010000);
		rd(5'h00, 32'h0);
		$display("end save");
		@(posedge clk) opndReady <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			h = nHalt;
			wr(5'h06, k ? 32'h38000000 : 32'h18000000);
			`CHK("halt", 1'b1, nHalt > h)
			rd(5'h06, k ? 32'h38000000 : 32'h18000000);
			for (int j = 0; j < 6; j++) begin
				if (k == 1 && j == 2) fork
					begin
						repeat (20) @(posedge clk);
						opndReady <= 1'b1;
					end
				join_none
				expQ.push_back({k[3:0], j[3:0], 24'hD00D00});
				wr(5'h10, {k[3:0], j[3:0], 24'hD00D00});
				if (k == 1 && j == 2) `CHK("fullStall", 1'b1, n > 20)
			end
		end
		wr(5'h06, 32'h0);
		rd(5'h06, 32'h0);
		rd(5'h00, 32'h0);
		wr(5'h06, 32'h12340000);
		rd(5'h06, 32'h02010000);
		wr(5'h02, 32'h00010000);
		rd(5'h00, 32'h0);
		repeat (20) @(posedge clk);
		`CHK("expQ", 0, expQ.size())
		$display("end restore");
		reportAndStop;
	end
endmodule
`default_nettype wire

// >>> design/cpif_bus_if.sv
// cpif_bus_if: coprocessor bus cycle wires between host and device
// assumes: both ends share one clock; reads drive rdData, writes drive wrData
`default_nettype none
interface cpif_bus_if;
	logic csN;
	logic readNotWrite;
	logic [4:0] addr;
	logic [31:0] wrData;
	logic [31:0] rdData;
	logic ackHiN;
	logic ackLoN;
	modport dev (input csN, readNotWrite, addr, wrData, output rdData, ackHiN, ackLoN);
	modport host (output csN, readNotWrite, addr, wrData, input rdData, ackHiN, ackLoN);
endinterface
`default_nettype wire

// >>> design/cpif_device.sv
// cpif_device: coprocessor end of the interface register dialog
// assumes: host holds csN low until an acknowledge, then raises it for a cycle;
// operand data written by the host drains through an 8-word buffer to the user side
// Behaviour
// - select register by A0-A4 under select
// - word registers on upper half, high ack
// - opcode and operand pointer: ignore, all ones
// - drop read-only writes, write-only reads ones
// - every selected cycle gets an acknowledge
// - response read always legal
// - instruction starts at first response read
// - transfer request read yields null, await operand
// - control bit 1 ack, bit 0 cancel
// - first generation: any control write cancels
// - first generation cancel clears exceptions, idles
// - second generation cancel inside window, restore fault or save frame transfer
// - second generation cancel ends windowed instruction
// - exception stays until acked and cleared
// - save read suspends work, starts save
// - save format word picks next access
// - save read during frame transfer: invalid
// - restore write halts work, prepares load
// - restore readback: word or invalid exception
// - host transfers frame or cancels after check
// - select from function code, space, identifier
// - busy command held, answer null come-again
`default_nettype none
module cpif_device #(
	parameter bit SECOND_GEN = 1'b1,
	parameter int DEPTH = cpif_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// host bus
	cpif_bus_if.dev bus,
	// instruction start towards the arithmetic unit
	output logic startPulse,
	output logic [15:0] startWord,
	input wire logic execBusy,
	output logic cancelPulse,
	output logic haltPulse,
	// exceptions
	input wire logic excRaise,
	input wire logic excCauseClear,
	output logic excPending,
	// operand stream out and context words in
	output logic opndValid,
	input wire logic opndReady,
	output logic [31:0] opndData,
	input wire logic [31:0] ctxRdData,
	input wire logic [7:0] regMaskIn
);
	logic fifoInReady;
	cpif_pkg::cpif_state_e state_reg, state_next;
	cpif_pkg::cpif_kind_e kind;
	logic [15:0] resp_reg, resp_next, cmd_reg, cmd_next, rest_reg, rest_next;
	logic held_reg, held_next, exc_reg, exc_next, xack_reg, xack_next;
	logic served_reg, served_next, ackHi_reg, ackHi_next, ackLo_reg, ackLo_next;
	logic start_reg, start_next, cancel_reg, cancel_next, halt_reg, halt_next;
	logic [31:0] rdData_reg, rdData_next, onesWord;
	logic [4:0] cnt_reg, cnt_next;
	logic active, isRead, push, window, wide;
	assign kind = cpif_pkg::cpif_decode(bus.addr);
	assign wide = (bus.addr[4:2] == cpif_pkg::OFF_OPERAND[4:2])
		|| (bus.addr[4:3] == cpif_pkg::OFF_INSTR_PTR[4:3]);
	assign onesWord = wide ? cpif_pkg::ALL_ONES_32 : {cpif_pkg::ALL_ONES_16, 16'h0000};
	assign isRead = bus.readNotWrite;
	assign active = !bus.csN && !served_reg;
	assign window = (state_reg == cpif_pkg::ST_CMD_HELD) || (state_reg == cpif_pkg::ST_OPND_WAIT);
	assign push = active && !isRead && (kind == cpif_pkg::RK_OPERAND) && fifoInReady
		&& ((state_reg == cpif_pkg::ST_OPND_WAIT) || (state_reg == cpif_pkg::ST_REST_XFER));
	cpif_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.srst(srst),
		.inValid(push),
		.inReady(fifoInReady),
		.inData(bus.wrData),
		.outValid(opndValid),
		.outReady(opndReady),
		.outData(opndData)
	);
	// ==========================================
	// dialog next state
	always_comb begin
		logic stall;
		stall = 1'b0;
		state_next = state_reg;
		resp_next = resp_reg;
		cmd_next = cmd_reg;
		rest_next = rest_reg;
		held_next = held_reg;
		exc_next = exc_reg;
		xack_next = xack_reg;
		cnt_next = cnt_reg;
		rdData_next = rdData_reg;
		start_next = 1'b0;
		cancel_next = 1'b0;
		halt_next = 1'b0;
		// exception sticks until acked and cause cleared
		if (exc_reg && xack_reg && excCauseClear) begin
			exc_next = 1'b0;
			xack_next = 1'b0;
		end
		if (excRaise) exc_next = 1'b1;
		// held command starts its dialog once the unit frees
		if (held_reg && !execBusy && state_reg == cpif_pkg::ST_IDLE) begin
			held_next = 1'b0;
			state_next = cpif_pkg::ST_CMD_HELD;
			resp_next = cpif_pkg::RESP_XFER_DATA;
		end
		if (active) begin
			// reads default to all ones, writes leave read data alone
			if (isRead) rdData_next = onesWord;
			case (kind)
				cpif_pkg::RK_RESPONSE: begin
					if (isRead) begin
						rdData_next = {exc_reg ? cpif_pkg::RESP_TAKE_EXC : resp_reg, 16'h0000};
						if (state_reg == cpif_pkg::ST_CMD_HELD && !exc_reg) begin
							start_next = 1'b1;
							// transfer read advances to operand wait
							state_next = cpif_pkg::ST_OPND_WAIT;
							resp_next = cpif_pkg::RESP_NULL_CA_IA;
						end
					end
				end
				cpif_pkg::RK_CONTROL: begin
					if (!isRead) begin
						if (!SECOND_GEN) begin
							cancel_next = 1'b1;
							exc_next = excRaise;
							xack_next = 1'b0;
							held_next = 1'b0;
							state_next = cpif_pkg::ST_IDLE;
							resp_next = cpif_pkg::RESP_NULL_IDLE;
						end else begin
							if (bus.wrData[16 + cpif_pkg::CTRL_EXC_ACK_BIT]) xack_next = 1'b1;
							// cancel inside the window, during a save frame transfer, or to leave a frame fault
							if (bus.wrData[16 + cpif_pkg::CTRL_CANCEL_BIT] && (window
								|| state_reg == cpif_pkg::ST_REST_FAIL
								|| state_reg == cpif_pkg::ST_SAVE_XFER)) begin
								cancel_next = 1'b1;
								state_next = cpif_pkg::ST_IDLE;
								resp_next = cpif_pkg::RESP_NULL_IDLE;
							end
						end
					end
				end
				cpif_pkg::RK_SAVE: begin
					if (isRead) begin
						if (state_reg == cpif_pkg::ST_SAVE_XFER
							|| state_reg == cpif_pkg::ST_REST_XFER) begin
							rdData_next = {cpif_pkg::FMT_INVALID, 16'h0000};
						end else if (execBusy) begin
							// suspend, ask for another save read
							halt_next = 1'b1;
							state_next = cpif_pkg::ST_SAVE_WAIT;
							rdData_next = {cpif_pkg::FMT_NOT_READY, 16'h0000};
						end else if (state_reg == cpif_pkg::ST_IDLE && !exc_reg && !held_reg) begin
							state_next = cpif_pkg::ST_IDLE;
							rdData_next = {cpif_pkg::FMT_NULL, 16'h0000};
						end else begin
							// idle frame follows on the operand register
							halt_next = 1'b1;
							state_next = cpif_pkg::ST_SAVE_XFER;
							cnt_next = cpif_pkg::FRAME_WORDS;
							rdData_next = {cpif_pkg::FMT_IDLE, 16'h0000};
						end
					end
				end
				cpif_pkg::RK_RESTORE: begin
					if (!isRead) begin
						// restore write halts and prepares load
						halt_next = 1'b1;
						held_next = 1'b0;
						rest_next = bus.wrData[31:16];
						state_next = cpif_pkg::ST_REST_CHECK;
					end else begin
						rdData_next = {rest_reg, 16'h0000};
						if (state_reg == cpif_pkg::ST_REST_CHECK) begin
							if (rest_reg == cpif_pkg::FMT_IDLE || rest_reg == cpif_pkg::FMT_BUSY) begin
								state_next = cpif_pkg::ST_REST_XFER;
								cnt_next = cpif_pkg::FRAME_WORDS;
							end else if (rest_reg == cpif_pkg::FMT_NULL) begin
								state_next = cpif_pkg::ST_IDLE;
							end else begin
								rdData_next = {cpif_pkg::FMT_INVALID_EXC, 16'h0000};
								rest_next = cpif_pkg::FMT_INVALID_EXC;
								state_next = cpif_pkg::ST_REST_FAIL;
							end
						end
					end
				end
				cpif_pkg::RK_COMMAND: begin
					if (!isRead && !window) begin
						cmd_next = bus.wrData[31:16];
						if (execBusy || held_reg) begin
							held_next = 1'b1;
							resp_next = cpif_pkg::RESP_NULL_CA_IA;
						end else begin
							state_next = cpif_pkg::ST_CMD_HELD;
							resp_next = cpif_pkg::RESP_XFER_DATA;
						end
					end else if (!isRead) begin
						resp_next = cpif_pkg::RESP_PROTO_VIOL;
					end
				end
				cpif_pkg::RK_OPERAND: begin
					if (state_reg == cpif_pkg::ST_SAVE_XFER && isRead) begin
						rdData_next = ctxRdData;
						cnt_next = cnt_reg - 1'b1;
						if (cnt_reg == 5'h01) state_next = cpif_pkg::ST_IDLE;
					end else if (push) begin
						if (state_reg == cpif_pkg::ST_OPND_WAIT) begin
							state_next = cpif_pkg::ST_IDLE;
							resp_next = cpif_pkg::RESP_NULL_IDLE;
						end else begin
							cnt_next = cnt_reg - 1'b1;
							if (cnt_reg == 5'h01) state_next = cpif_pkg::ST_IDLE;
						end
					end else if (!isRead && !fifoInReady) begin
						// back-pressure: hold the cycle until the buffer has room
						stall = 1'b1;
					end else begin
						resp_next = cpif_pkg::RESP_PROTO_VIOL;
					end
				end
				cpif_pkg::RK_REGMASK: begin
					if (isRead) rdData_next = {regMaskIn, 24'h000000};
				end
				default: if (isRead) rdData_next = onesWord;
			endcase
		end
		// acknowledge every selected cycle; word registers use the high ack only
		ackHi_next = active && !stall;
		ackLo_next = active && !stall && wide;
		served_next = bus.csN ? 1'b0 : (served_reg || (active && !stall));
	end
	// dialog registers forced idle by reset
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= cpif_pkg::ST_IDLE;
			resp_reg <= cpif_pkg::RESP_NULL_IDLE;
			rest_reg <= cpif_pkg::FMT_NULL;
			{cmd_reg, cnt_reg, rdData_reg} <= '0;
			{held_reg, exc_reg, xack_reg, start_reg, cancel_reg, halt_reg} <= '0;
			{ackHi_reg, ackLo_reg, served_reg} <= '0;
		end else begin
			state_reg <= state_next;
			{resp_reg, cmd_reg, rest_reg} <= {resp_next, cmd_next, rest_next};
			{cnt_reg, rdData_reg} <= {cnt_next, rdData_next};
			{held_reg, exc_reg, xack_reg, start_reg, cancel_reg, halt_reg} <= {held_next, exc_next,
				xack_next, start_next, cancel_next, halt_next};
			{ackHi_reg, ackLo_reg, served_reg} <= {ackHi_next, ackLo_next, served_next};
		end
	end
	assign bus.rdData = rdData_reg;
	assign bus.ackHiN = !ackHi_reg;
	assign bus.ackLoN = !ackLo_reg;
	assign {startPulse, startWord, cancelPulse} = {start_reg, cmd_reg, cancel_reg};
	assign {haltPulse, excPending} = {halt_reg, exc_reg};
endmodule
`default_nettype wire

// >>> design/cpif_fifo.sv
// cpif_fifo: synchronous first-in first-out buffer with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`default_nettype none
module cpif_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [AW:0] count_reg, count_next;
	logic push, pop;

	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push) wrPtr_next = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		if (pop) rdPtr_next = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		if (push && !pop) count_next = count_reg + 1'b1;
		else if (pop && !push) count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
		if (push) mem[wrPtr_reg] <= inData;
	end
endmodule
`default_nettype wire

// >>> design/cpif_host.sv
// cpif_host: host end that runs one coprocessor bus cycle per selected request
// assumes: device acknowledges while csN is low; csN stays high for at least two cycles after each
`default_nettype none
module cpif_host #(
	parameter logic [2:0] COPROC_ID = 3'h1
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// host bus
	cpif_bus_if.host bus,
	// request
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqRead,
	input wire logic [2:0] reqFc,
	input wire logic [3:0] reqSpace,
	input wire logic [2:0] reqCpId,
	input wire logic [4:0] reqAddr,
	input wire logic [31:0] reqWData,
	// answer
	output logic rspValid,
	output logic rspNoDevice,
	output logic rspWide,
	output logic [31:0] rspData
);
	typedef enum logic [1:0] {HS_IDLE = 2'h0, HS_DRIVE = 2'h1, HS_GAP = 2'h2} cpif_hstate_e;
	cpif_hstate_e st_reg, st_next;
	logic cs_reg, cs_next, rd_reg, rd_next, rv_reg, rv_next, nd_reg, nd_next, wd_reg, wd_next;
	logic [4:0] addr_reg, addr_next;
	logic [31:0] wd32_reg, wd32_next, rsp_reg, rsp_next;
	logic hit;

	// select from function code, space type and identifier
	assign hit = (reqFc == cpif_pkg::FC_CPU_SPACE) && (reqSpace == cpif_pkg::SPACE_COPROC)
		&& (reqCpId == COPROC_ID);
	assign reqReady = (st_reg == HS_IDLE);

	always_comb begin
		st_next = st_reg;
		cs_next = cs_reg;
		rd_next = rd_reg;
		addr_next = addr_reg;
		wd32_next = wd32_reg;
		rsp_next = rsp_reg;
		rv_next = 1'b0;
		nd_next = nd_reg;
		wd_next = wd_reg;
		case (st_reg)
			HS_IDLE: begin
				if (reqValid && hit) begin
					st_next = HS_DRIVE;
					cs_next = 1'b1;
					rd_next = reqRead;
					addr_next = reqAddr;
					wd32_next = reqWData;
				end else if (reqValid) begin
					rv_next = 1'b1;
					nd_next = 1'b1;
					rsp_next = cpif_pkg::ALL_ONES_32;
				end
			end
			HS_DRIVE: begin
				if (!bus.ackHiN || !bus.ackLoN) begin
					// frame and cancel sequencing is left to the requester
					st_next = HS_GAP;
					cs_next = 1'b0;
					rv_next = 1'b1;
					nd_next = 1'b0;
					wd_next = !bus.ackLoN;
					rsp_next = bus.rdData;
				end
			end
			HS_GAP: st_next = HS_IDLE;
			default: st_next = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= HS_IDLE;
			cs_reg <= 1'b0;
			rd_reg <= 1'b1;
			addr_reg <= 5'h00;
			wd32_reg <= 32'h00000000;
			rsp_reg <= 32'h00000000;
			rv_reg <= 1'b0;
			nd_reg <= 1'b0;
			wd_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cs_reg <= cs_next;
			rd_reg <= rd_next;
			addr_reg <= addr_next;
			wd32_reg <= wd32_next;
			rsp_reg <= rsp_next;
			rv_reg <= rv_next;
			nd_reg <= nd_next;
			wd_reg <= wd_next;
		end
	end

	assign bus.csN = !cs_reg;
	assign bus.readNotWrite = rd_reg;
	assign bus.addr = addr_reg;
	assign bus.wrData = wd32_reg;
	assign rspValid = rv_reg;
	assign rspNoDevice = nd_reg;
	assign rspWide = wd_reg;
	assign rspData = rsp_reg;
endmodule
`default_nettype wire

// >>> design/cpif_pkg.sv
// cpif_pkg: interface register offsets, format words, primitives and dialog states
// assumes: a five-bit register select field and a 32-bit data path
`default_nettype none
package cpif_pkg;
	// ==========================================
	// register select field (byte offsets, A4-A0)
	localparam logic [4:0] OFF_RESPONSE = 5'h00;
	localparam logic [4:0] OFF_CONTROL = 5'h02;
	localparam logic [4:0] OFF_SAVE = 5'h04;
	localparam logic [4:0] OFF_RESTORE = 5'h06;
	localparam logic [4:0] OFF_OPWORD = 5'h08;
	localparam logic [4:0] OFF_COMMAND = 5'h0A;
	localparam logic [4:0] OFF_RSVD_0C = 5'h0C;
	localparam logic [4:0] OFF_CONDITION = 5'h0E;
	localparam logic [4:0] OFF_OPERAND = 5'h10;
	localparam logic [4:0] OFF_REGMASK = 5'h14;
	localparam logic [4:0] OFF_RSVD_16 = 5'h16;
	localparam logic [4:0] OFF_INSTR_PTR = 5'h18;
	localparam logic [4:0] OFF_OPND_PTR = 5'h1C;
	// ==========================================
	// control register fields
	localparam int CTRL_EXC_ACK_BIT = 1;
	localparam int CTRL_CANCEL_BIT = 0;
	// ==========================================
	// response primitives (bit 15 come again, bit 14 instruction accept)
	localparam logic [15:0] RESP_NULL_IDLE = 16'h0000;
	localparam logic [15:0] RESP_NULL_CA_IA = 16'hC000;
	localparam logic [15:0] RESP_XFER_DATA = 16'h8100;
	localparam logic [15:0] RESP_TAKE_EXC = 16'h1C00;
	localparam logic [15:0] RESP_PROTO_VIOL = 16'h1C01;
	// ==========================================
	// state frame format words
	localparam logic [15:0] FMT_NULL = 16'h0000;
	localparam logic [15:0] FMT_NOT_READY = 16'h0100;
	localparam logic [15:0] FMT_INVALID = 16'h0200;
	localparam logic [15:0] FMT_IDLE = 16'h1800;
	localparam logic [15:0] FMT_BUSY = 16'h3800;
	localparam logic [15:0] FMT_INVALID_EXC = 16'h0201;
	localparam logic [15:0] ALL_ONES_16 = 16'hFFFF;
	localparam logic [31:0] ALL_ONES_32 = 32'hFFFFFFFF;
	// ==========================================
	// chip select decode, frame length and buffer depth
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	localparam logic [3:0] SPACE_COPROC = 4'h2;
	localparam logic [4:0] FRAME_WORDS = 5'h06;
	localparam int FIFO_DEPTH = 8;
	// ==========================================
	// dialog states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CMD_HELD = 4'h1,
		ST_OPND_WAIT = 4'h2,
		ST_SAVE_WAIT = 4'h3,
		ST_SAVE_XFER = 4'h4,
		ST_REST_CHECK = 4'h5,
		ST_REST_XFER = 4'h6,
		ST_REST_FAIL = 4'h7
	} cpif_state_e;
	// register kinds
	typedef enum logic [3:0] {
		RK_RESPONSE = 4'h0, RK_CONTROL = 4'h1, RK_SAVE = 4'h2, RK_RESTORE = 4'h3,
		RK_COMMAND = 4'h4, RK_CONDITION = 4'h5, RK_OPERAND = 4'h6, RK_REGMASK = 4'h7,
		RK_INSTR_PTR = 4'h8, RK_UNUSED = 4'h9
	} cpif_kind_e;

	function automatic cpif_kind_e cpif_decode(input logic [4:0] a);
		cpif_kind_e k;
		k = RK_UNUSED;
		if (a[4:2] == OFF_OPERAND[4:2]) k = RK_OPERAND;
		else if (a[4:2] == OFF_INSTR_PTR[4:2]) k = RK_INSTR_PTR;
		else if (a[4:2] == OFF_OPND_PTR[4:2]) k = RK_UNUSED;
		else if (a[4:1] == OFF_RESPONSE[4:1]) k = RK_RESPONSE;
		else if (a[4:1] == OFF_CONTROL[4:1]) k = RK_CONTROL;
		else if (a[4:1] == OFF_SAVE[4:1]) k = RK_SAVE;
		else if (a[4:1] == OFF_RESTORE[4:1]) k = RK_RESTORE;
		else if (a[4:1] == OFF_COMMAND[4:1]) k = RK_COMMAND;
		else if (a[4:1] == OFF_CONDITION[4:1]) k = RK_CONDITION;
		else if (a[4:1] == OFF_REGMASK[4:1]) k = RK_REGMASK;
		return k;
	endfunction
endpackage
`default_nettype wire
